// ==== hw/smc_cfg.svh ====
// Purpose: constants of the serial master channel
// Assumes: included by bare name from package and modules
// Notes: widths, reset values and field codes live here only
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH
// widths
`define SMC_DATA_W 32
`define SMC_CS_N 8
`define SMC_CNT_W 8
`define SMC_LEN_W 6
`define SMC_IDX_W 5
`define SMC_EDGE_W 7
`define SMC_DLY_W 12
`define SMC_DIV_W 12
`define SMC_HALF_W 18
`define SMC_PRI_W 3
`define SMC_LVL_W 4
`define SMC_OUTPUT_LEVEL_IDLE_SELECT_W 2
`define SMC_PRCS_W 2
// reset values and fixed figures
`define SMC_LEN_MAX 6'h20
`define SMC_PRI_RST 4'h8
`define SMC_CS_RST 8'hff
`define SMC_ONE_CNT 8'h01
`define SMC_ONE_DLY 12'h001
`define SMC_ONE_DIV 12'h001
// idle level codes of the data output
`define SMC_OUTPUT_LEVEL_IDLE_SELECT_HOLD 2'h0
`define SMC_OUTPUT_LEVEL_IDLE_SELECT_LOW 2'h1
`define SMC_OUTPUT_LEVEL_IDLE_SELECT_HIGH 2'h2
`endif

// ==== hw/smc_pkg.sv ====
// Purpose: types of the serial master channel
// Assumes: smc_cfg.svh gives all widths
// Notes: every module keeps its state in one packed struct
`include "smc_cfg.svh"
package smc_pkg;
  // channel sequencer states
  typedef enum logic [2:0] {
    SMC_IDLE, SMC_WAIT_TX, SMC_SETUP, SMC_SHIFT,
    SMC_HOLD, SMC_GAP, SMC_GAP_ALT, SMC_END_GAP
  } smc_state_t;

  // whole state of the channel
  typedef struct packed {
    smc_state_t st;
    logic run;
    logic [`SMC_CNT_W-1:0] fcnt;
    logic [`SMC_DATA_W-1:0] tx_data;
    logic par_tx;
    logic [`SMC_DATA_W-1:0] rx_sh;
    logic par_rx;
    logic [`SMC_DATA_W-1:0] rx_data;
    logic [`SMC_EDGE_W-1:0] ecnt;
    logic sck;
    logic sdo;
    logic [`SMC_CS_N-1:0] cs;
    logic rx_rdy;
    logic perr;
    logic tx_irq;
    logic fe_irq;
    logic job_end;
    logic [`SMC_LVL_W-1:0] pri;
  } smc_chan_t;

  // state of the delay timer and of the baud divider
  typedef struct packed {
    logic [`SMC_DLY_W-1:0] cnt;
  } smc_tmr_t;

  typedef struct packed {
    logic [`SMC_HALF_W-1:0] cnt;
  } smc_div_t;
endpackage

// ==== hw/smc_delay_timer.sv ====
// Purpose: counts a programmed number of module clocks
// Assumes: load comes in the cycle the caller enters its timed state
// Notes: a zero value still waits one cycle
`timescale 1ns/1ps
`include "smc_cfg.svh"
module smc_delay_timer
  import smc_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // control
  input wire logic i_load,
  input wire logic [`SMC_DLY_W-1:0] i_val,
  // status
  output logic o_done
);
  smc_tmr_t q, d;

  //////////////////////////////////////////////////////////////////////
  // next count: done is seen when one cycle is left
  always_comb begin
    d = q;
    if (i_load) begin
      d.cnt = (i_val == '0) ? `SMC_ONE_DLY : i_val;
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - `SMC_ONE_DLY;
    end
  end

  assign o_done = (q.cnt == `SMC_ONE_DLY);

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// ==== hw/smc_baud_gen.sv ====
// Purpose: half-period ticks of the serial clock
// Assumes: run is held for the whole shift phase
// Notes: half period = divider shifted left by twice the exponent
`timescale 1ns/1ps
`include "smc_cfg.svh"
module smc_baud_gen
  import smc_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // control
  input wire logic i_run,
  input wire logic [`SMC_PRCS_W-1:0] i_prescaler_exp,
  input wire logic [`SMC_DIV_W-1:0] i_divider,
  // one pulse per serial clock edge
  output logic o_tick
);
  smc_div_t q, d;
  logic [`SMC_DIV_W-1:0] div;
  logic [`SMC_HALF_W-1:0] half;

  //////////////////////////////////////////////////////////////////////
  // a zero divider would stall the link, so it counts as one
  always_comb begin
    div = (i_divider == '0) ? `SMC_ONE_DIV : i_divider;
    half = `SMC_HALF_W'(div) << {i_prescaler_exp, 1'b0};
    o_tick = i_run && (q.cnt == half - `SMC_HALF_W'(1));
    d = q;
    if (!i_run || o_tick) begin
      d.cnt = '0;
    end else begin
      d.cnt = q.cnt + `SMC_HALF_W'(1);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// ==== hw/smc_master_channel.sv ====
// Purpose: master channel of a multichannel serial interface
// Assumes: all settings are static while the channel runs
// Notes: one channel, software trigger, direct word transfer
`timescale 1ns/1ps
`include "smc_cfg.svh"
module smc_master_channel
  import smc_pkg::*;
#(
  parameter int DATA_W = `SMC_DATA_W,
  parameter int CS_N = `SMC_CS_N
)
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // unit settings
  input wire logic i_module_enable,
  input wire logic i_role_select,
  input wire logic i_receive_capture_timing,
  input wire logic i_clock_rest_level,
  input wire logic [`SMC_OUTPUT_LEVEL_IDLE_SELECT_W-1:0] i_output_level_idle_select,
  input wire logic [`SMC_CS_N-1:0] i_cs_polarity,
  input wire logic i_internal_loop_enable,
  // channel settings
  input wire logic [`SMC_PRI_W-1:0] i_channel_priority,
  input wire logic i_frame_count_continue,
  input wire logic i_clock_polarity_sel,
  input wire logic i_clock_phase_sel,
  input wire logic i_bit_order,
  input wire logic i_cs_return_inactive,
  input wire logic i_frame_end_gap_insert,
  input wire logic i_parity_kind,
  input wire logic i_parity_check_enable,
  input wire logic [`SMC_CNT_W-1:0] i_frame_count_setting,
  input wire logic [`SMC_LEN_W-1:0] i_frame_bit_length,
  input wire logic [`SMC_PRCS_W-1:0] i_baud_prescaler_exp,
  input wire logic [`SMC_DIV_W-1:0] i_baud_divider,
  input wire logic [`SMC_DLY_W-1:0] i_cs_to_clock_delay,
  input wire logic [`SMC_DLY_W-1:0] i_cs_negate_delay,
  input wire logic [`SMC_DLY_W-1:0] i_next_frame_gap,
  input wire logic [`SMC_DLY_W-1:0] i_next_frame_delay_alt,
  input wire logic i_job_end_flag,
  input wire logic [`SMC_CS_N-1:0] i_cs_line_select,
  // software commands
  input wire logic i_channel_start,
  input wire logic i_channel_stop,
  input wire logic i_tx_data_write,
  input wire logic [`SMC_DATA_W-1:0] i_tx_data_reg,
  // serial pins
  input wire logic i_serial_data_in,
  output logic o_serial_clock_pin,
  output logic o_serial_data_out,
  output logic [`SMC_CS_N-1:0] o_chip_select_out,
  // status and events
  output logic o_channel_run_enable,
  output logic [`SMC_LVL_W-1:0] o_priority_level,
  output logic [`SMC_DATA_W-1:0] o_rx_data,
  output logic o_rx_ready,
  output logic o_parity_error,
  output logic o_tx_irq,
  output logic o_frame_end_irq,
  output logic o_job_end
);
  // the state struct is fixed by the header widths
  if (DATA_W != `SMC_DATA_W || CS_N != `SMC_CS_N) begin : g_bad_cfg
    $error("smc_master_channel: widths must match smc_cfg.svh");
  end

  //////////////////////////////////////////////////////////////////////
  // helpers

  // lengths of zero or above the word are served as a full word
  function automatic logic [`SMC_LEN_W-1:0] eff_len(
    input logic [`SMC_LEN_W-1:0] len);
    eff_len = (len == '0 || len > `SMC_LEN_MAX) ? `SMC_LEN_MAX : len;
  endfunction

  // word bit carried by serial slot j, shared by transmit and receive
  function automatic logic [`SMC_IDX_W-1:0] bit_pos(
    input logic [`SMC_EDGE_W-1:0] j,
    input logic [`SMC_LEN_W-1:0] len,
    input logic lsb_first);
    logic [`SMC_EDGE_W-1:0] p;
    p = lsb_first ? j : `SMC_EDGE_W'(len) - j - `SMC_EDGE_W'(1);
    bit_pos = p[`SMC_IDX_W-1:0];
  endfunction

  //////////////////////////////////////////////////////////////////////
  // state, sub-blocks and derived terms
  smc_chan_t q, d;
  logic tick;
  logic tmr_done;
  logic tmr_load;
  logic [`SMC_DLY_W-1:0] tmr_val;
  logic [`SMC_LEN_W-1:0] len;
  logic [`SMC_EDGE_W-1:0] n_bits;
  logic [`SMC_EDGE_W-1:0] two_n;
  logic [`SMC_EDGE_W-1:0] last_e;
  logic [`SMC_CS_N-1:0] cs_off;
  logic [`SMC_CS_N-1:0] cs_on;
  logic rx_in;
  logic [`SMC_DATA_W-1:0] mask;

  smc_baud_gen u_baud (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_run(q.st == SMC_SHIFT),
    .i_prescaler_exp(i_baud_prescaler_exp),
    .i_divider(i_baud_divider),
    .o_tick(tick)
  );

  smc_delay_timer u_tmr (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_load(tmr_load),
    .i_val(tmr_val),
    .o_done(tmr_done)
  );

  // frame geometry and select levels
  always_comb begin
    len = eff_len(i_frame_bit_length);
    n_bits = `SMC_EDGE_W'(len) + `SMC_EDGE_W'(i_parity_check_enable);
    two_n = n_bits << 1;
    // with phase 1, a delayed capture of the last bit needs one extra half period
    last_e = two_n + `SMC_EDGE_W'(i_clock_phase_sel &
                                  i_receive_capture_timing);
    cs_off = ~i_cs_polarity;
    cs_on = ~(i_cs_line_select ^ i_cs_polarity);
    rx_in = i_internal_loop_enable ? q.sdo : i_serial_data_in;
    mask = ~({`SMC_DATA_W{1'b1}} << len);
  end

  //////////////////////////////////////////////////////////////////////
  // channel sequencer
  always_comb begin
    logic [`SMC_EDGE_W-1:0] e;
    logic [`SMC_EDGE_W-1:0] dv;
    logic [`SMC_EDGE_W-1:0] sv;
    logic [`SMC_EDGE_W-1:0] s_first;
    logic [`SMC_EDGE_W-1:0] j;
    logic [`SMC_DATA_W-1:0] rxv;
    logic last;
    e = '0;
    dv = '0;
    sv = '0;
    s_first = '0;
    j = '0;
    rxv = q.rx_sh;
    last = 1'b0;
    d = q;
    tmr_load = 1'b0;
    tmr_val = i_cs_to_clock_delay;
    // event outputs are single-cycle pulses
    d.rx_rdy = 1'b0;
    d.tx_irq = 1'b0;
    d.fe_irq = 1'b0;
    d.job_end = 1'b0;
    d.pri = `SMC_LVL_W'(i_channel_priority) + `SMC_LVL_W'(1);
    case (q.st)
      SMC_IDLE: begin
        d.sck = i_clock_rest_level;
        d.cs = cs_off;
        if (i_output_level_idle_select == `SMC_OUTPUT_LEVEL_IDLE_SELECT_LOW) begin
          d.sdo = 1'b0;
        end else if (i_output_level_idle_select == `SMC_OUTPUT_LEVEL_IDLE_SELECT_HIGH) begin
          d.sdo = 1'b1;
        end
        // master role only; the slave role is another block
        if (i_channel_start && !i_role_select) begin
          d.run = 1'b1;
          d.fcnt = i_frame_count_setting;
          d.st = SMC_WAIT_TX;
          d.tx_irq = 1'b1;
        end
      end
      SMC_WAIT_TX: begin
        d.sck = i_clock_polarity_sel;
        if (i_channel_stop) begin
          d.run = 1'b0;
          d.cs = cs_off;
          d.st = SMC_IDLE;
        end else if (i_tx_data_write) begin
          d.tx_data = i_tx_data_reg & mask;
          // parity bit makes the ones count odd for kind 0
          d.par_tx = ^(i_tx_data_reg & mask) ^ ~i_parity_kind;
          d.cs = cs_on;
          d.st = SMC_SETUP;
          tmr_load = 1'b1;
          tmr_val = i_cs_to_clock_delay;
        end
      end
      SMC_SETUP: begin
        if (tmr_done) begin
          d.st = SMC_SHIFT;
          d.ecnt = '0;
          d.rx_sh = '0;
          d.par_rx = 1'b0;
          // phase 0 puts the first bit out before the first edge
          if (!i_clock_phase_sel) begin
            d.sdo = q.tx_data[bit_pos('0, len, i_bit_order)];
          end
        end
      end
      SMC_SHIFT: begin
        if (tick) begin
          e = q.ecnt + `SMC_EDGE_W'(1);
          d.ecnt = e;
          if (e <= two_n) begin
            d.sck = ~q.sck;
          end
          // launch slot j on edge 2j+phase
          dv = e - `SMC_EDGE_W'(i_clock_phase_sel);
          j = dv >> 1;
          if (e <= two_n && !dv[0] && j < n_bits) begin
            if (j == `SMC_EDGE_W'(len)) begin
              d.sdo = q.par_tx;
            end else begin
              d.sdo = q.tx_data[bit_pos(j, len, i_bit_order)];
            end
          end
          // capture slot j on edge 2j+1+phase, plus one when delayed
          s_first = `SMC_EDGE_W'(1) + `SMC_EDGE_W'(i_clock_phase_sel) +
                    `SMC_EDGE_W'(i_receive_capture_timing);
          sv = e - s_first;
          j = sv >> 1;
          if (e >= s_first && !sv[0] && j < n_bits) begin
            if (j == `SMC_EDGE_W'(len)) begin
              d.par_rx = rx_in;
            end else begin
              rxv[bit_pos(j, len, i_bit_order)] = rx_in;
            end
          end
          d.rx_sh = rxv;
          if (e == last_e) begin
            d.rx_data = rxv;
            d.rx_rdy = 1'b1;
            d.perr = i_parity_check_enable &&
                     ((^rxv ^ d.par_rx) == i_parity_kind);
            d.st = SMC_HOLD;
            tmr_load = 1'b1;
            tmr_val = i_cs_negate_delay;
          end
        end
      end
      SMC_HOLD: begin
        if (tmr_done) begin
          // the select line stays active between frames otherwise
          if (i_cs_return_inactive) begin
            d.cs = cs_off;
          end
          last = (q.fcnt <= `SMC_ONE_CNT);
          d.fcnt = q.fcnt - `SMC_ONE_CNT;
          d.job_end = !i_job_end_flag || last;
          d.sck = i_clock_polarity_sel;
          tmr_load = 1'b1;
          tmr_val = i_next_frame_gap;
          if (last) begin
            d.fe_irq = 1'b1;
            if (i_frame_count_continue) begin
              d.fcnt = i_frame_count_setting;
              d.st = SMC_GAP;
            end else begin
              d.run = 1'b0;
              d.st = i_frame_end_gap_insert ? SMC_END_GAP
                                            : SMC_IDLE;
              if (!i_frame_end_gap_insert) begin
                d.cs = cs_off;
              end
            end
          end else begin
            d.st = SMC_GAP;
          end
        end
      end
      SMC_GAP: begin
        if (tmr_done) begin
          d.st = SMC_GAP_ALT;
          tmr_load = 1'b1;
          tmr_val = i_next_frame_delay_alt;
        end
      end
      SMC_GAP_ALT: begin
        if (tmr_done) begin
          d.st = SMC_WAIT_TX;
          d.tx_irq = 1'b1;
        end
      end
      SMC_END_GAP: begin
        if (tmr_done) begin
          d.cs = cs_off;
          d.st = SMC_IDLE;
        end
      end
      default: begin
        d.st = SMC_IDLE;
      end
    endcase
    // disabling the unit drops any transfer and parks data out low
    if (!i_module_enable) begin
      d.st = SMC_IDLE;
      d.run = 1'b0;
      d.cs = cs_off;
      d.sck = i_clock_rest_level;
      d.sdo = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // state register; reset leaves selects negated for active-low lines
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      q <= '0;
      q.st <= SMC_IDLE;
      q.cs <= `SMC_CS_RST;
      q.pri <= `SMC_PRI_RST;
    end else begin
      q <= d;
    end
  end

  // every output is a register bit
  assign o_serial_clock_pin = q.sck;
  assign o_serial_data_out = q.sdo;
  assign o_chip_select_out = q.cs;
  assign o_channel_run_enable = q.run;
  assign o_priority_level = q.pri;
  assign o_rx_data = q.rx_data;
  assign o_rx_ready = q.rx_rdy;
  assign o_parity_error = q.perr;
  assign o_tx_irq = q.tx_irq;
  assign o_frame_end_irq = q.fe_irq;
  assign o_job_end = q.job_end;
endmodule

// ==== bench/smc_master_monitor.sv ====
// Purpose: port checker of the serial master channel
// Assumes: half period 4 clocks, setup 2, select polarity low
// Notes: figures follow the bench settings
`timescale 1ns/1ps
`include "smc_cfg.svh"
module smc_master_monitor (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // watched settings and the write strobe
  input wire logic i_clock_rest_level,
  input wire logic [`SMC_CS_N-1:0] i_cs_polarity,
  input wire logic [`SMC_PRI_W-1:0] i_channel_priority,
  input wire logic [`SMC_CS_N-1:0] i_cs_line_select,
  input wire logic i_tx_data_write,
  // watched outputs
  input wire logic o_serial_clock_pin,
  input wire logic o_serial_data_out,
  input wire logic [`SMC_CS_N-1:0] o_chip_select_out,
  input wire logic o_channel_run_enable,
  input wire logic [`SMC_LVL_W-1:0] o_priority_level,
  input wire logic o_tx_irq,
  input wire logic o_frame_end_irq,
  input wire logic o_job_end
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  //////////////////////////////////////////////////////////////////////////
  // first edge waits setup plus one half period after select
  sequence setup_wait;
    !o_serial_clock_pin [*6] ##1 o_serial_clock_pin;
  endsequence
  // a write accepted one cycle after the request pulse
  sequence write_after_irq;
    o_tx_irq ##1 i_tx_data_write;
  endsequence
  cs_idle_a: assert property (
    !o_channel_run_enable && !$past(o_channel_run_enable)
    |-> o_chip_select_out == ~i_cs_polarity) else $error("cs not idle");
  cs_lines_a: assert property (
    ((o_chip_select_out ^ ~i_cs_polarity) & ~i_cs_line_select) == '0)
    else $error("unselected line active");
  sck_rest_a: assert property (
    !o_channel_run_enable |-> o_serial_clock_pin == i_clock_rest_level)
    else $error("clock not at rest");
  tx_irq_a: assert property (
    $rose(o_channel_run_enable) |-> o_tx_irq) else $error("no tx request");
  cs_write_a: assert property (
    write_after_irq |=> o_chip_select_out[0] == i_cs_polarity[0])
    else $error("select late");
  setup_a: assert property (
    $fell(o_chip_select_out[0]) |-> setup_wait) else $error("setup time");
  half_a: assert property (
    $rose(o_serial_clock_pin) |-> o_serial_clock_pin [*4]
    ##1 !o_serial_clock_pin) else $error("half period");
  run_clear_a: assert property (
    o_frame_end_irq |-> $fell(o_channel_run_enable)) else $error("run on");
  prio_lvl_a: assert property (
    o_priority_level == {1'b0, $past(i_channel_priority)} + 4'h1)
    else $error("priority level");
  job_end_a: assert property (
    o_job_end |-> o_chip_select_out[0] && !$past(o_chip_select_out[0]))
    else $error("job end");
  sdo_hold_a: assert property (
    o_chip_select_out[0] && $past(o_chip_select_out[0])
    |-> $stable(o_serial_data_out)) else $error("data out moved");
  frame_gap_a: assert property (
    $rose(o_chip_select_out[0]) && o_channel_run_enable
    |-> o_chip_select_out[0] [*8]) else $error("gap short");
endmodule
bind smc_master_channel smc_master_monitor i_mon (.i_clk_sys, .i_rst_b,
  .i_clock_rest_level, .i_cs_polarity, .i_channel_priority,
  .i_cs_line_select, .i_tx_data_write, .o_serial_clock_pin,
  .o_serial_data_out, .o_chip_select_out, .o_channel_run_enable,
  .o_priority_level, .o_tx_irq, .o_frame_end_irq, .o_job_end);

// ==== bench/smc_slave_model.sv ====
// Purpose: behavioural slave on the far side of the channel
// Assumes: clock phase 1, clock rests low, select active low
// Notes: a released data line shows the inverse of its last bit
`timescale 1ns/1ps
module smc_slave_model (
  // serial pins
  input wire logic i_sck,
  input wire logic i_cs_b,
  input wire logic i_mosi,
  output logic o_miso,
  // word to send and word received
  input wire logic [31:0] i_word,
  output logic [31:0] o_got
);
  logic [31:0] sh = 32'h0;
  logic bit_q = 1'b0;
  //////////////////////////////////////////////////////////////////////////
  // fresh word per select, so stale data cannot pass
  always @(negedge i_cs_b) begin
    sh = i_word;
    o_got = 32'h0;
  end
  // odd edges shift out msb first
  always @(posedge i_sck) begin
    if (!i_cs_b) begin
      bit_q = sh[31];
      sh = sh << 1;
    end
  end
  // even edges sample the master
  always @(negedge i_sck) begin
    if (!i_cs_b) begin
      o_got = {o_got[30:0], i_mosi};
    end
  end
  // deselected: inverted level, not the last bit
  assign o_miso = i_cs_b ? ~bit_q : bit_q;
endmodule

// ==== bench/smc_master_channel_bench.sv ====
// Purpose: self-checking bench of the serial master channel
// Assumes: phase 1, late capture, half period 4 clocks
// Notes: queue model of expected words, slave model on line 0
`timescale 1ns/1ps
`include "smc_cfg.svh"
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin \
  err_total++; $display("wrong value %s exp %h got %h", nm, ex, gt); \
  end end
module smc_master_channel_bench;
  logic i_clk_sys, i_rst_b, i_receive_capture_timing;
  logic i_internal_loop_enable, i_frame_count_continue;
  logic i_clock_polarity_sel, i_clock_phase_sel, i_bit_order;
  logic i_cs_return_inactive, i_frame_end_gap_insert, i_parity_kind;
  logic i_parity_check_enable, i_job_end_flag, i_channel_start;
  logic i_channel_stop, i_tx_data_write, i_serial_data_in, i_role_select;
  logic [2:0] i_channel_priority;
  logic [7:0] i_frame_count_setting, i_cs_line_select;
  logic [5:0] i_frame_bit_length;
  logic [1:0] i_baud_prescaler_exp;
  logic [11:0] i_baud_divider, i_cs_to_clock_delay, i_cs_negate_delay;
  logic [11:0] i_next_frame_gap, i_next_frame_delay_alt;
  logic [31:0] i_tx_data_reg, o_rx_data, slave_word, slave_got, mw, sw, ev;
  logic o_serial_clock_pin, o_serial_data_out, o_channel_run_enable;
  logic o_rx_ready, o_parity_error, o_tx_irq, o_frame_end_irq, o_job_end;
  logic [7:0] o_chip_select_out;
  logic [3:0] o_priority_level;
  logic [31:0] exp_q[$];
  int seed = 32'h5a61;
  int err_total = 0, compares = 0, cycles = 0, n_tx, n_fe, n_job, w0;
  //////////////////////////////////////////////////////////////////////////
  // ties: enabled unit, select active low, clock rest low, idle data out held
  smc_master_channel i_dut (.i_module_enable(1'b1), .i_role_select,
    .i_clock_rest_level(1'b0), .i_output_level_idle_select(2'h0),
    .i_cs_polarity(8'h00), .i_clk_sys, .i_rst_b, .i_receive_capture_timing,
    .i_internal_loop_enable, .i_channel_priority, .i_frame_count_continue,
    .i_clock_polarity_sel, .i_clock_phase_sel, .i_bit_order,
    .i_cs_return_inactive, .i_frame_end_gap_insert, .i_parity_kind,
    .i_parity_check_enable, .i_frame_count_setting, .i_frame_bit_length,
    .i_baud_prescaler_exp, .i_baud_divider, .i_cs_to_clock_delay,
    .i_cs_negate_delay, .i_next_frame_gap, .i_next_frame_delay_alt,
    .i_job_end_flag, .i_cs_line_select, .i_channel_start, .i_channel_stop,
    .i_tx_data_write, .i_tx_data_reg, .i_serial_data_in,
    .o_serial_clock_pin, .o_serial_data_out, .o_chip_select_out,
    .o_channel_run_enable, .o_priority_level, .o_rx_data, .o_rx_ready,
    .o_parity_error, .o_tx_irq, .o_frame_end_irq, .o_job_end);
  smc_slave_model i_slave (.i_sck(o_serial_clock_pin),
    .i_cs_b(o_chip_select_out[0]), .i_mosi(o_serial_data_out),
    .o_miso(i_serial_data_in), .i_word(slave_word), .o_got(slave_got));
  //////////////////////////////////////////////////////////////////////////
  // clock and event counters; the ceiling cuts a hang short
  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cycles++;
    n_tx += int'(o_tx_irq === 1'b1);
    n_fe += int'(o_frame_end_irq === 1'b1);
    n_job += int'(o_job_end === 1'b1);
    if (cycles == 6000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // bounded wait, sampled at the falling edge where outputs are settled
  task automatic wait_for(ref logic s, output int w);
    w = 0;
    do begin
      @(negedge i_clk_sys);
      w++;
    end while (s !== 1'b1 && w < 600);
    // a wait that runs out is a failure, not a silent pass
    if (s !== 1'b1) begin
      err_total++;
      stop_test();
    end
  endtask
  // one run of n frames; frame 0 also gets a refused start and write
  task automatic run_job(input logic [7:0] n, input logic [1:0] pe,
      input logic [11:0] dv, input logic lb);
    int w;
    logic [2:0] pr;
    pr = 3'($random(seed));
    @(negedge i_clk_sys);
    {n_tx, n_fe, n_job} = {32'h0, 32'h0, 32'h0};
    @(posedge i_clk_sys);
    {i_frame_count_setting, i_baud_prescaler_exp} <= {n, pe};
    i_baud_divider <= dv;
    i_internal_loop_enable <= lb;
    i_channel_priority <= pr;
    i_channel_start <= 1'b1;
    @(posedge i_clk_sys);
    i_channel_start <= 1'b0;
    for (int k = 0; k < n; k++) begin
      wait_for(o_tx_irq, w);
      if (k > 0) `CHK("frame gap", 1'b1, w >= 10)
      mw = $random(seed);
      sw = $random(seed);
      // loop-back returns our own word, otherwise the slave's
      exp_q.push_back(lb ? mw : sw);
      @(posedge i_clk_sys);
      {i_tx_data_reg, slave_word, i_tx_data_write} <= {mw, sw, 1'b1};
      @(posedge i_clk_sys);
      i_tx_data_write <= 1'b0;
      if (k == 0) begin
        repeat (10) @(posedge i_clk_sys);
        {i_channel_start, i_tx_data_write, i_tx_data_reg} <= {2'h3, ~mw};
        @(posedge i_clk_sys);
        {i_channel_start, i_tx_data_write} <= 2'h0;
      end
      wait_for(o_rx_ready, w);
      ev = exp_q.pop_front();
      `CHK("rx data", ev, o_rx_data)
      `CHK("parity error", 1'b0, o_parity_error)
      `CHK("slave word", mw, slave_got)
      `CHK("selects", 8'hfe, o_chip_select_out)
    end
    repeat (20) @(negedge i_clk_sys);
    `CHK("run enable", 1'b0, o_channel_run_enable)
    `CHK("frame end count", 1, n_fe)
    `CHK("tx request count", int'(n), n_tx)
    `CHK("job end count", int'(n), n_job)
    `CHK("priority", {1'b0, pr} + 4'h1, o_priority_level)
    $display("run of %0d frames done", n);
  endtask
  //////////////////////////////////////////////////////////////////////////
  // settings as the loop-back example; role master keeps select input off
  initial begin
    {i_rst_b, i_channel_start, i_channel_stop, i_tx_data_write} = 4'h0;
    i_role_select = 1'b0;
    {i_receive_capture_timing, i_internal_loop_enable} = 2'h2;
    {i_clock_polarity_sel, i_clock_phase_sel, i_bit_order} = 3'h2;
    {i_cs_return_inactive, i_frame_end_gap_insert} = 2'h2;
    {i_parity_kind, i_parity_check_enable, i_job_end_flag} = 3'h0;
    {i_frame_count_continue, i_channel_priority} = 4'h7;
    {i_frame_count_setting, i_cs_line_select} = 16'h0401;
    {i_frame_bit_length, i_baud_prescaler_exp} = 8'h80;
    {i_baud_divider, i_cs_to_clock_delay} = 24'h004002;
    {i_cs_negate_delay, i_next_frame_gap} = 24'h001001;
    i_next_frame_delay_alt = 12'h008;
    {i_tx_data_reg, slave_word} = 64'h0;
    repeat (2) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    @(negedge i_clk_sys);
    `CHK("reset selects", 8'hff, o_chip_select_out)
    `CHK("reset clock", 1'b0, o_serial_clock_pin)
    `CHK("reset data out", 1'b0, o_serial_data_out)
    @(negedge i_clk_sys);
    `CHK("priority default", 4'h8, o_priority_level)
    $display("reset values done");
    run_job(8'h04, 2'h0, 12'h004, 1'b0);
    run_job(8'h02, 2'h1, 12'h001, 1'b0);
    run_job(8'h01, 2'h0, 12'h004, 1'b1);
    // slave role refuses a start; a stop while waiting ends the run
    @(posedge i_clk_sys);
    {i_channel_start, i_role_select} <= 2'h3;
    @(posedge i_clk_sys);
    {i_channel_start, i_role_select} <= 2'h0;
    repeat (2) @(negedge i_clk_sys);
    `CHK("slave role start", 1'b0, o_channel_run_enable)
    @(posedge i_clk_sys);
    i_channel_start <= 1'b1;
    @(posedge i_clk_sys);
    i_channel_start <= 1'b0;
    wait_for(o_tx_irq, w0);
    @(posedge i_clk_sys);
    i_channel_stop <= 1'b1;
    @(posedge i_clk_sys);
    i_channel_stop <= 1'b0;
    @(negedge i_clk_sys);
    `CHK("stop run", 1'b0, o_channel_run_enable)
    `CHK("stop selects", 8'hff, o_chip_select_out)
    $display("refused start and stop done");
    stop_test();
  end
endmodule
